// ===== cec_params.svh
// Purpose: constants for the cascaded event counter
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes:   offsets, field positions, reset values
`ifndef CEC_PARAMS_SVH
`define CEC_PARAMS_SVH
`define CEC_ADDR_W        6
`define CEC_OFF_MODE      6'h00
`define CEC_OFF_CLKSEL    6'h04
`define CEC_OFF_OUTCTL    6'h08
`define CEC_OFF_LOCMP     6'h0c
`define CEC_OFF_HICMP     6'h10
`define CEC_OFF_COUNT     6'h14
`define CEC_OFF_STATUS    6'h18
`define CEC_OFF_MASK      6'h1c
`define CEC_MODE_EN_BIT   0
`define CEC_MODE_CAS_BIT  2
`define CEC_OUT_SQ_BIT    4
`define CEC_ST_LO_BIT     0
`define CEC_ST_FULL_BIT   1
`define CEC_MASK_RESET    2'h3
`define CEC_SEL_RISE      4'h0
`define CEC_SEL_FALL      4'h1
`define CEC_SEL_SYS_MIN   4'h6
`define CEC_CLK_NS        100
`endif

// ===== cec_pkg.sv
// Purpose: shared types of the cascaded event counter
// Assumes: cec_params.svh gives the numbers
// Notes:   types only
package cec_pkg;
  typedef struct packed {
    logic       en;
    logic       cascade;
    logic       sq_en;
    logic [3:0] clk_sel;
  } cec_ctrl_s;
  typedef struct packed {
    logic       lo_match;
    logic       full_match;
    logic       lo_wrap;
  } cec_evt_s;
  typedef enum logic [2:0] {
    CEC_IDLE = 3'b001,
    CEC_READ = 3'b010,
    CEC_DONE = 3'b100
  } cec_bus_e;
endpackage

// ===== cec_tick.sv
// Purpose: count pulse generator for the low counter
// Assumes: event input synchronous to mclk
// Notes:   edge select or prescaled system clock
`timescale 1ns/10ps
`include "cec_params.svh"
module cec_tick
  import cec_pkg::*;
#(
  parameter int PRE_W = 12
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // control
  input  wire logic       run,
  input  wire logic [3:0] sel,
  input  wire logic       event_input,
  // pulse
  output logic            tick
);
  initial begin
    if (PRE_W < 12) $error("prescaler too narrow");
  end
  logic             ev_d;
  logic [PRE_W-1:0] pre;
  logic             rise;
  logic             fall;
  logic [3:0]       tap;

  // ones at bit t and below; a variable part-select is not legal here
  function automatic logic [PRE_W-1:0] low_ones(input logic [3:0] t);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++) begin
      if (i <= int'(t)) m[i] = 1'b1;
    end
    return m;
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ev_d <= 1'b0;
    else         ev_d <= event_input;
  end
  // prescaler is cleared while stopped, so the first period is a full one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)   pre <= '0;
    else if (!run) pre <= '0;
    else           pre <= pre + 1'b1;
  end
  assign rise = event_input & ~ev_d;
  assign fall = ~event_input & ev_d;
  assign tap  = sel - `CEC_SEL_SYS_MIN;
  always_comb begin
    tick = 1'b0;
    if (run) begin
      if (sel == `CEC_SEL_RISE)      tick = rise;
      else if (sel == `CEC_SEL_FALL) tick = fall;
      else if (sel >= `CEC_SEL_SYS_MIN)
        tick = (pre & low_ones(tap)) == low_ones(tap);
    end
  end
endmodule

// ===== cec_top.sv
// Function
// - low counter advances on each selected rising or falling event edge
// - high counter advances whenever the low counter wraps in cascade mode
// - both halves equal compares: clear counters, raise full match flag
// - low half match raises low match flag and toggles output flop
// - square output toggles on each full interval when enabled
// - half period is one to 65536 count clock periods
// - first match after start may be up to one count period off
// - compare below count gives no match until wrap and recount
// - cascade bit two of mode control selects 16-bit mode
// - high compare holds upper eight bits, low compare lower eight
// - four-bit field bits 0 to 3 select the count clock
//
// Purpose: two 8-bit counters chained as one 16-bit timer/event counter
// Assumes: Avalon-MM slave, 32-bit data, one clock mclk at 10 MHz
// Notes:   low match output flop is visible on low_toggle_out
`timescale 1ns/10ps
`include "cec_params.svh"
module cec_top
  import cec_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  // avalon-mm slave
  input  wire logic [`CEC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // pins
  input  wire logic                   event_input,
  output logic                        square_wave_out,
  output logic                        low_toggle_out,
  // interrupt
  output logic                        irq
);
  initial begin
    if (CNT_W != 8) $error("counter halves must be 8 bits");
  end

  cec_ctrl_s        ctrl;
  logic [CNT_W-1:0] low_compare;
  logic [CNT_W-1:0] high_compare;
  logic [CNT_W-1:0] low_byte_counter;
  logic [CNT_W-1:0] high_byte_counter;
  logic [1:0]       status;
  logic [1:0]       mask;
  cec_bus_e         bus_st;
  cec_evt_s         evt;
  logic             tick;
  logic             run;
  logic             wr;
  logic             lo_eq;
  logic             hi_eq;

  function automatic logic hit(input logic [`CEC_ADDR_W-1:0] off);
    return avs_address == off;
  endfunction

  // writes take effect at once; reads answer two cycles later
  assign wr  = avs_write && avs_byteenable[0];
  assign run = ctrl.en;
  always_comb begin
    avs_waitrequest = 1'b0;
    if (avs_read && bus_st != CEC_DONE) avs_waitrequest = 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_st <= CEC_IDLE;
    end else begin
      unique case (bus_st)
        CEC_IDLE: if (avs_read) bus_st <= CEC_READ;
        CEC_READ: bus_st <= CEC_DONE;
        CEC_DONE: bus_st <= CEC_IDLE;
        default:  bus_st <= CEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl         <= '0;
      low_compare  <= '0;
      high_compare <= '0;
      mask         <= `CEC_MASK_RESET;
    end else if (wr) begin
      if (hit(`CEC_OFF_MODE)) begin
        ctrl.en      <= avs_writedata[`CEC_MODE_EN_BIT];
        ctrl.cascade <= avs_writedata[`CEC_MODE_CAS_BIT];
      end
      if (hit(`CEC_OFF_CLKSEL)) ctrl.clk_sel <= avs_writedata[3:0];
      if (hit(`CEC_OFF_OUTCTL))
        ctrl.sq_en <= avs_writedata[`CEC_OUT_SQ_BIT];
      if (hit(`CEC_OFF_LOCMP)) low_compare  <= avs_writedata[7:0];
      if (hit(`CEC_OFF_HICMP)) high_compare <= avs_writedata[7:0];
      if (hit(`CEC_OFF_MASK))  mask <= avs_writedata[1:0];
    end
  end

  // read data captured once, so both count halves come from one cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= '0;
    end else if (bus_st == CEC_READ) begin
      avs_readdata <= '0;
      unique case (avs_address)
        `CEC_OFF_MODE: begin
          avs_readdata[`CEC_MODE_EN_BIT]  <= ctrl.en;
          avs_readdata[`CEC_MODE_CAS_BIT] <= ctrl.cascade;
        end
        `CEC_OFF_CLKSEL: avs_readdata[3:0] <= ctrl.clk_sel;
        `CEC_OFF_OUTCTL: avs_readdata[`CEC_OUT_SQ_BIT] <= ctrl.sq_en;
        `CEC_OFF_LOCMP:  avs_readdata[7:0] <= low_compare;
        `CEC_OFF_HICMP:  avs_readdata[7:0] <= high_compare;
        `CEC_OFF_COUNT:
          avs_readdata[15:0] <= {high_byte_counter, low_byte_counter};
        `CEC_OFF_STATUS: avs_readdata[1:0] <= status;
        `CEC_OFF_MASK:   avs_readdata[1:0] <= mask;
        default:         avs_readdata <= '0;
      endcase
    end
  end

  cec_tick #(
    .PRE_W (12)
  ) u_tick (
    .mclk        (mclk),
    .resetn      (resetn),
    .run         (run),
    .sel         (ctrl.clk_sel),
    .event_input (event_input),
    .tick        (tick)
  );

  // equality only, never less-than: a lowered compare waits for a wrap
  assign lo_eq = low_byte_counter == low_compare;
  assign hi_eq = high_byte_counter == high_compare;
  always_comb begin
    evt.lo_wrap    = tick && (low_byte_counter == '1);
    evt.lo_match   = tick && lo_eq;
    evt.full_match = tick && lo_eq && (hi_eq || !ctrl.cascade);
  end

  // low counter; start is not aligned to the count pulse
  // a stop clears both halves, so a restart recounts from zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)             low_byte_counter <= '0;
    else if (evt.full_match) low_byte_counter <= '0;
    else if (!ctrl.en)       low_byte_counter <= '0;
    else if (tick)
      low_byte_counter <= low_byte_counter + 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)             high_byte_counter <= '0;
    else if (evt.full_match) high_byte_counter <= '0;
    else if (!ctrl.en)       high_byte_counter <= '0;
    else if (evt.lo_wrap && ctrl.cascade)
      high_byte_counter <= high_byte_counter + 1'b1;
  end

  // sticky flags; a new event wins over a write-one clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      if (wr && hit(`CEC_OFF_STATUS)) status <= status & ~avs_writedata[1:0];
      if (evt.lo_match)   status[`CEC_ST_LO_BIT]   <= 1'b1;
      if (evt.full_match) status[`CEC_ST_FULL_BIT] <= 1'b1;
    end
  end
  // mask resets to all ones so neither match flag raises irq
  assign irq = |(status & ~mask);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)           low_toggle_out <= 1'b0;
    else if (evt.lo_match) low_toggle_out <= ~low_toggle_out;
  end

  // half period = (compare + 1) count periods, 1 to 65536
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) square_wave_out <= 1'b0;
    else if (evt.full_match && ctrl.sq_en)
      square_wave_out <= ~square_wave_out;
  end

  property p_full_clear;
    @(posedge mclk) disable iff (!resetn)
      evt.full_match |=> (low_byte_counter == '0 && high_byte_counter == '0
                          && status[`CEC_ST_FULL_BIT]);
  endproperty
  a_full_clear: assert property (p_full_clear)
    else $error("full match did not clear and flag");

  property p_low_step;
    @(posedge mclk) disable iff (!resetn)
      (tick && !evt.full_match) |=>
        low_byte_counter == $past(low_byte_counter) + 8'h01;
  endproperty
  a_low_step: assert property (p_low_step)
    else $error("low counter did not advance");

  property p_high_step;
    @(posedge mclk) disable iff (!resetn)
      (evt.lo_wrap && ctrl.cascade && !evt.full_match) |=>
        high_byte_counter == $past(high_byte_counter) + 8'h01;
  endproperty
  a_high_step: assert property (p_high_step)
    else $error("high counter missed low wrap");

  property p_high_hold;
    @(posedge mclk) disable iff (!resetn)
      (!evt.lo_wrap && !evt.full_match && ctrl.en)
        |=> $stable(high_byte_counter);
  endproperty
  a_high_hold: assert property (p_high_hold)
    else $error("high counter moved without wrap");

  property p_lo_toggle;
    @(posedge mclk) disable iff (!resetn)
      evt.lo_match |=> (low_toggle_out != $past(low_toggle_out))
                       && status[`CEC_ST_LO_BIT];
  endproperty
  a_lo_toggle: assert property (p_lo_toggle)
    else $error("low match did not toggle");

  property p_sq_toggle;
    @(posedge mclk) disable iff (!resetn)
      (evt.full_match && ctrl.sq_en) |=> $changed(square_wave_out);
  endproperty
  a_sq_toggle: assert property (p_sq_toggle)
    else $error("square output missed toggle");

  property p_sq_hold;
    @(posedge mclk) disable iff (!resetn)
      !(evt.full_match && ctrl.sq_en) |=> $stable(square_wave_out);
  endproperty
  a_sq_hold: assert property (p_sq_hold)
    else $error("square output moved while idle");

  property p_no_early;
    @(posedge mclk) disable iff (!resetn)
      (tick && !lo_eq) |-> !evt.full_match;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("match without equality");

  property p_stop_clear;
    @(posedge mclk) disable iff (!resetn)
      !ctrl.en |=> (low_byte_counter == '0 && high_byte_counter == '0);
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stopped counter not cleared");

  property p_status_sticky;
    @(posedge mclk) disable iff (!resetn)
      (status[`CEC_ST_LO_BIT]
       && !(wr && hit(`CEC_OFF_STATUS) && avs_writedata[`CEC_ST_LO_BIT]))
        |=> status[`CEC_ST_LO_BIT];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("low match flag lost without clear");

  // system ticks come at most every other cycle
  property p_sys_gap;
    @(posedge mclk) disable iff (!resetn)
      (tick && ctrl.clk_sel >= `CEC_SEL_SYS_MIN) |=>
        (!tick || $changed(ctrl.clk_sel));
  endproperty
  a_sys_gap: assert property (p_sys_gap)
    else $error("system tick faster than half rate");

  property p_zero_cmp;
    @(posedge mclk) disable iff (!resetn)
      (tick && low_compare == 8'h00 && high_compare == 8'h00
       && low_byte_counter == 8'h00 && high_byte_counter == 8'h00)
        |-> evt.full_match;
  endproperty
  a_zero_cmp: assert property (p_zero_cmp)
    else $error("zero compare missed match");

  property p_read_lat;
    @(posedge mclk) disable iff (!resetn)
      (avs_read && bus_st == CEC_IDLE) |-> avs_waitrequest ##2 !avs_waitrequest;
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read answer latency wrong");

  c_full: cover property (@(posedge mclk) disable iff (!resetn)
    evt.full_match && ctrl.cascade);
  c_wrap: cover property (@(posedge mclk) disable iff (!resetn)
    evt.lo_wrap && ctrl.cascade);
  c_sq: cover property (@(posedge mclk) disable iff (!resetn)
    evt.full_match && ctrl.sq_en);
  c_irq: cover property (@(posedge mclk) disable iff (!resetn) $rose(irq));
  c_sys: cover property (@(posedge mclk) disable iff (!resetn)
    tick && ctrl.clk_sel >= `CEC_SEL_SYS_MIN);
endmodule

// ===== cec_evsrc.sv
// Purpose: far side model, event pulse source and square output watcher
// Assumes: pulses synchronous to mclk, two cycles high, two cycles low
// Notes:   every pulse carries one rising and one falling edge
`timescale 1ns/10ps
module cec_evsrc (
  // clock
  input  wire logic        mclk,
  // pins
  input  wire logic        square_wave_out,
  output logic             event_input,
  // observation
  output logic [15:0]      sq_edges
);
  logic sq_q;
  initial begin
    event_input = 1'b0;
    sq_edges = 16'h0;
    sq_q = 1'b0;
  end
  // level held two cycles so no edge is lost to the sampling
  task automatic send(input int n);
    repeat (n) begin
      @(posedge mclk) event_input <= 1'b1;
      @(posedge mclk);
      @(posedge mclk) event_input <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // any level change counts, so a stray toggle shows up
  always @(posedge mclk) begin
    sq_q <= square_wave_out;
    if (square_wave_out !== sq_q) sq_edges <= sq_edges + 16'h1;
  end
endmodule

// ===== cec_test.sv
// Purpose: self-checking bench of the cascaded event counter
// Assumes: read answer after two cycles, writes taken at once
// Notes:   each row starts from reset, so flags start clear
`timescale 1ns/10ps
`include "cec_params.svh"
module cec_test
  import cec_pkg::*;
;
  typedef struct {
    logic [3:0]  mode;
    logic [3:0]  sel;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [31:0] oc;
    int          n;
    logic [31:0] cnt;
    logic [31:0] st;
    logic [15:0] sq;
  } cec_row_s;
  logic                   mclk;
  logic                   resetn;
  logic [`CEC_ADDR_W-1:0] avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [3:0]             avs_byteenable;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   event_input;
  logic                   square_wave_out;
  logic                   low_toggle_out;
  logic                   irq;
  logic [15:0]            sq_edges;
  logic [15:0]            base;
  logic [31:0]            v;
  int                     bad_count;
  int                     n_tests;
  cec_row_s               rows [6];
  cec_top #(.CNT_W(8)) uut (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_input(event_input), .square_wave_out(square_wave_out),
    .low_toggle_out(low_toggle_out), .irq(irq)
  );
  cec_evsrc src (
    .mclk(mclk), .square_wave_out(square_wave_out),
    .event_input(event_input), .sq_edges(sq_edges)
  );
  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (t >= 50) chk("bus answer", 32'h1, 32'h0);
    v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rst;
    @(posedge mclk) resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
  endtask
  task automatic cfg(input cec_row_s r);
    rst();
    bus(1'b1, `CEC_OFF_MODE, 32'h0);
    bus(1'b1, `CEC_OFF_LOCMP, {24'h0, r.lo});
    bus(1'b1, `CEC_OFF_HICMP, {24'h0, r.hi});
    bus(1'b1, `CEC_OFF_CLKSEL, {28'h0, r.sel});
    bus(1'b1, `CEC_OFF_OUTCTL, r.oc);
    bus(1'b1, `CEC_OFF_MODE, {28'h0, r.mode});
    base = sq_edges;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #3000000;
    bad_count++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    bad_count = 0;
    n_tests = 0;
    // mode sel lo hi outctl pulses count status toggles
    rows = '{
      '{4'h5, 4'h0, 8'h03, 8'h00, 32'h10, 5, 32'h1, 32'h3, 16'h1},
      '{4'h5, 4'h1, 8'h00, 8'h00, 32'h10, 4, 32'h0, 32'h3, 16'h4},
      '{4'h5, 4'h0, 8'h02, 8'h01, 32'h10, 256, 32'h100, 32'h1, 16'h0},
      '{4'h5, 4'h0, 8'h02, 8'h01, 32'h10, 260, 32'h1, 32'h3, 16'h1},
      '{4'h1, 4'h0, 8'h02, 8'h05, 32'h10, 3, 32'h0, 32'h3, 16'h1},
      '{4'h5, 4'h0, 8'h00, 8'h00, 32'h0, 3, 32'h0, 32'h3, 16'h0}
    };
    rst();
    bus(1'b0, `CEC_OFF_MASK, 32'h0);
    chk("mask reset", v, {30'h0, `CEC_MASK_RESET});
    bus(1'b0, `CEC_OFF_STATUS, 32'h0);
    chk("status reset", v, 32'h0);
    bus(1'b0, `CEC_OFF_COUNT, 32'h0);
    chk("count reset", v, 32'h0);
    bus(1'b1, 6'h20, 32'hff);
    bus(1'b0, 6'h20, 32'h0);
    chk("unmapped read", v, 32'h0);
    chk("square reset", {31'h0, square_wave_out}, 32'h0);
    foreach (rows[i]) begin
      cfg(rows[i]);
      src.send(rows[i].n);
      repeat (3) @(posedge mclk);
      bus(1'b0, `CEC_OFF_COUNT, 32'h0);
      chk("count", v, rows[i].cnt);
      bus(1'b0, `CEC_OFF_STATUS, 32'h0);
      chk("status", v, rows[i].st);
      chk("toggles", {16'h0, sq_edges - base}, {16'h0, rows[i].sq});
      chk("irq masked", {31'h0, irq}, 32'h0);
    end
    // both status bits are set here, interrupt paths checked one by one
    bus(1'b1, `CEC_OFF_MASK, 32'h2);
    @(negedge mclk);
    chk("irq low", {31'h0, irq}, 32'h1);
    bus(1'b1, `CEC_OFF_STATUS, 32'h1);
    @(negedge mclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b0, `CEC_OFF_STATUS, 32'h0);
    chk("status w1c", v, 32'h2);
    bus(1'b1, `CEC_OFF_MASK, 32'h0);
    @(negedge mclk);
    chk("irq full", {31'h0, irq}, 32'h1);
    bus(1'b1, `CEC_OFF_STATUS, 32'h2);
    @(negedge mclk);
    chk("irq off", {31'h0, irq}, 32'h0);
    // compare lowered under the count while running: no early match
    cfg('{4'h5, 4'h0, 8'h10, 8'h00, 32'h10, 0, 32'h0, 32'h0, 16'h0});
    src.send(8);
    bus(1'b1, `CEC_OFF_LOCMP, 32'h4);
    src.send(8);
    repeat (3) @(posedge mclk);
    bus(1'b0, `CEC_OFF_COUNT, 32'h0);
    chk("count past compare", v, 32'h10);
    bus(1'b0, `CEC_OFF_STATUS, 32'h0);
    chk("no early match", v, 32'h0);
    // restart after lowering: stop clears, next match comes at the new value
    bus(1'b1, `CEC_OFF_MODE, 32'h0);
    bus(1'b0, `CEC_OFF_COUNT, 32'h0);
    chk("count after stop", v, 32'h0);
    bus(1'b1, `CEC_OFF_MODE, 32'h5);
    src.send(5);
    repeat (3) @(posedge mclk);
    bus(1'b0, `CEC_OFF_STATUS, 32'h0);
    chk("match after restart", v, 32'h3);
    // prescaled system clock: count never passes the compare
    cfg('{4'h5, 4'h6, 8'h01, 8'h00, 32'h10, 0, 32'h0, 32'h0, 16'h0});
    repeat (40) @(posedge mclk);
    bus(1'b0, `CEC_OFF_COUNT, 32'h0);
    chk("system count", {v[31:1], 1'b0}, 32'h0);
    bus(1'b0, `CEC_OFF_STATUS, 32'h0);
    chk("system match", v, 32'h3);
    chk("system toggles", {31'h0, sq_edges != base}, 32'h1);
    finish_test();
  end
endmodule
